// ---- amp_cmd_cfg.svh ----
// offsets, field values, field positions and reset values for the
// millimetre amplifier power command decoder
// assumes: included by its bare name from the crc, register bus and decoder modules
`ifndef AMP_CMD_CFG_SVH
`define AMP_CMD_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_READBACK 4'h8
`define OFS_SEQ 4'hc

// ----------------------------------------------------------------------
// fixed packet header values
// ----------------------------------------------------------------------
`define PKT_VERSION 3'h0
`define PKT_TYPE_BIT 1'h1
`define PKT_DFH_FLAG 1'h1
`define PKT_APID 7'h47
`define PKT_CATEGORY 4'hc
`define PKT_SEQ_FLAGS 2'h3
`define PKT_SRC_GROUND 3'h0
`define PKT_LENGTH 16'h0007
`define PKT_PUS_VERSION 3'h0
`define PKT_CKSUM_FLAG 1'h1
`define PKT_ACK 4'h1
`define PKT_SVC_TYPE 8'hc0
`define PKT_SUBTYPE 8'h07
`define PKT_PAD 8'h00
`define PKT_WORDS 4'h8

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_REG_AMP_BIT 8
`define RDBK_AMP_BIT 7
`define AMP_CTRL_RESET 1'h0
`define CMD_POWER_ON 16'h0001
`define CMD_POWER_OFF 16'h0000

`endif

// ---- amp_cmd_pkg.sv ----
// types shared by the command decoder modules
// assumes: nothing beyond the config header
package amp_cmd_pkg;
  typedef enum logic [1:0] {
    PK_IDLE,
    PK_BODY,
    PK_CHECK
  } pkt_state_e;

  typedef enum logic [2:0] {
    VERDICT_NONE,
    VERDICT_OK,
    VERDICT_HEADER,
    VERDICT_SEQ,
    VERDICT_CKSUM,
    VERDICT_OTHER
  } verdict_e;
endpackage : amp_cmd_pkg

// ---- pkt_crc16.sv ----
// crc-16 (ccitt polynomial, preset all ones) over 16-bit words
// assumes: clear and word strobe come from the packet receiver
`timescale 1ns/100ps
`include "amp_cmd_cfg.svh"

module pkt_crc16 (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic wordValid,
  input wire logic [15:0] word,
  output logic [15:0] crc
);
  logic [15:0] next_crc;
  logic [15:0] acc;

  // ----------------------------------------------------------------------
  // bitwise update, msb first; a loop keeps one copy of the shift step
  // ----------------------------------------------------------------------
  always_comb begin
    acc = crc;
    for (int i = 15; i >= 0; i--) begin
      if (acc[15] ^ word[i]) begin
        acc = {acc[14:0], 1'b0} ^ 16'h1021;
      end else begin
        acc = {acc[14:0], 1'b0};
      end
    end
    next_crc = crc;
    if (clear) begin
      next_crc = 16'hffff;
    end else if (wordValid) begin
      next_crc = acc;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      crc <= 16'hffff;
    end else begin
      crc <= next_crc;
    end
  end
endmodule : pkt_crc16

// ---- avalon_regs.sv ----
// avalon-mm slave holding the control, status and readback words
// assumes: one request at a time; answer one cycle after it is raised
`timescale 1ns/100ps
`include "amp_cmd_cfg.svh"

module avalon_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [15:0] sensorUnitControlReg,
  input wire logic [15:0] readbackWord,
  input wire logic [31:0] statusWord,
  input wire logic [10:0] expectedSeq,
  output logic swRestart
);
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic next_swRestart;
  logic served;

  // ----------------------------------------------------------------------
  // one wait cycle, then answer; served stops a second answer
  // ----------------------------------------------------------------------
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = readdata;
    next_swRestart = 1'b0;
    if ((read || write) && waitrequest && !served) begin
      next_waitrequest = 1'b0;
      if (read) begin
        case (address)
          `OFS_CTRL: next_readdata = {16'h0000, sensorUnitControlReg};
          `OFS_STATUS: next_readdata = statusWord;
          `OFS_READBACK: next_readdata = {16'h0000, readbackWord};
          `OFS_SEQ: next_readdata = {21'h000000, expectedSeq};
          default: next_readdata = 32'h00000000; // unmapped reads zero
        endcase
      end
    end
    // a write lands only at the edge that completes the transfer
    if (write && !waitrequest && address == `OFS_CTRL && byteenable[0]
        && writedata[0]) begin
      next_swRestart = 1'b1; // software restart sets ampCtrl back to its reset value
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      swRestart <= 1'b0;
      served <= 1'b0;
    end else begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
      swRestart <= next_swRestart;
      served <= !next_waitrequest;
    end
  end
endmodule : avalon_regs

// ---- mm_amp_power_command_decoder.sv ----
// decoder for the millimetre amplifier power telecommand
// assumes: packets arrive as 16-bit words with a first-word marker,
// one word per cycle when tcValid is high; registers over avalon-mm
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "amp_cmd_cfg.svh"

module mm_amp_power_command_decoder #(
  parameter int SEQ_WIDTH = 11
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tcValid,
  input wire logic tcFirst,
  input wire logic [15:0] tcWord,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic ampCtrl,
  output logic cmdAccept,
  output logic cmdReject
);
  amp_cmd_pkg::pkt_state_e state;
  amp_cmd_pkg::pkt_state_e next_state;
  logic [3:0] wordIdx;
  logic [3:0] next_wordIdx;
  logic [15:0] hdr [0:7];
  logic [15:0] next_hdr [0:7];
  logic [SEQ_WIDTH-1:0] expectedSeq;
  logic [SEQ_WIDTH-1:0] next_expectedSeq;
  logic next_ampCtrl;
  logic next_cmdAccept;
  logic next_cmdReject;
  logic [7:0] acceptCount;
  logic [7:0] next_acceptCount;
  logic [7:0] rejectCount;
  logic [7:0] next_rejectCount;
  amp_cmd_pkg::verdict_e lastVerdict;
  amp_cmd_pkg::verdict_e next_lastVerdict;
  amp_cmd_pkg::verdict_e verdict;
  logic [15:0] crc;
  logic crcClear;
  logic crcFeed;
  logic swRestart;
  logic headerOk;
  logic classOk;
  logic seqOk;
  logic [15:0] sensorUnitControlReg;
  logic [15:0] readbackWord;
  logic [31:0] statusWord;
  // named views of the fixed header fields
  logic [2:0] versionField;
  logic typeBitField;
  logic dfhFlagField;
  logic [6:0] apidField;
  logic [3:0] categoryField;
  logic [1:0] seqFlagsField;
  logic [2:0] sourceField;
  logic [SEQ_WIDTH-1:0] seqCountField;
  logic [15:0] lengthField;
  logic spareField;
  logic [2:0] pusVersionField;
  logic cksumFlagField;
  logic [2:0] reservedField;
  logic [3:0] ackField;
  logic [7:0] svcTypeField;
  logic [7:0] subtypeField;
  logic [7:0] padField;
  logic [15:0] dataField;
  logic [15:0] checkField;

  // ----------------------------------------------------------------------
  // checksum and register bus
  // ----------------------------------------------------------------------
  // the crc runs over words 1 to 6; word 0 presets it and word 7 is the check word
  assign crcClear = tcValid && tcFirst;
  assign crcFeed = tcValid && !tcFirst && state == amp_cmd_pkg::PK_BODY
                   && wordIdx < `PKT_WORDS - 4'h1;

  pkt_crc16 u_crc (
    .mclk(mclk),
    .rst(rst),
    .clear(crcClear),
    .wordValid(crcFeed || crcClear),
    .word(tcWord),
    .crc(crc)
  );

  // word 0 only presets the crc: clear wins over the feed in the crc
  logic [15:0] crcFirst;

  avalon_regs u_regs (
    .mclk(mclk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .sensorUnitControlReg(sensorUnitControlReg),
    .readbackWord(readbackWord),
    .statusWord(statusWord),
    .expectedSeq(expectedSeq),
    .swRestart(swRestart)
  );

  // ----------------------------------------------------------------------
  // views of the control bit and the status word
  // ----------------------------------------------------------------------
  always_comb begin
    sensorUnitControlReg = 16'h0000;
    sensorUnitControlReg[`CTRL_REG_AMP_BIT] = ampCtrl;
    readbackWord = 16'h0000;
    readbackWord[`RDBK_AMP_BIT] = ampCtrl;
    statusWord = {13'h0000, lastVerdict, rejectCount, acceptCount};
  end

  // ----------------------------------------------------------------------
  // field views of the collected words
  // ----------------------------------------------------------------------
  // word layout: 0 id, 1 sequence, 2 length, 3 service header,
  // 4 type and subtype, 5 pad, 6 data, 7 check word
  always_comb begin
    versionField = hdr[0][15:13];
    typeBitField = hdr[0][12];
    dfhFlagField = hdr[0][11];
    apidField = hdr[0][10:4];
    categoryField = hdr[0][3:0];
    seqFlagsField = hdr[1][15:14];
    sourceField = hdr[1][13:11];
    seqCountField = hdr[1][SEQ_WIDTH-1:0];
    lengthField = hdr[2];
    spareField = hdr[3][15];
    pusVersionField = hdr[3][14:12];
    cksumFlagField = hdr[3][11];
    reservedField = hdr[3][10:8];
    ackField = hdr[3][3:0];
    svcTypeField = hdr[4][15:8];
    subtypeField = hdr[4][7:0];
    padField = hdr[5][7:0];
    dataField = hdr[6];
    checkField = hdr[7];
  end

  // ----------------------------------------------------------------------
  // header checks on the collected words
  // ----------------------------------------------------------------------
  // a header fault rejects the packet; nothing is executed from it
  always_comb begin
    headerOk = versionField == `PKT_VERSION
            && typeBitField == `PKT_TYPE_BIT
            && dfhFlagField == `PKT_DFH_FLAG
            && apidField == `PKT_APID
            && categoryField == `PKT_CATEGORY
            && seqFlagsField == `PKT_SEQ_FLAGS
            && sourceField == `PKT_SRC_GROUND
            && lengthField == `PKT_LENGTH
            && spareField == 1'b0
            && pusVersionField == `PKT_PUS_VERSION
            && cksumFlagField == `PKT_CKSUM_FLAG
            && reservedField == 3'h0
            && ackField == `PKT_ACK
            && padField == `PKT_PAD;
    // type 192 and subtype 7 pick this command out of the others
    classOk = svcTypeField == `PKT_SVC_TYPE
           && subtypeField == `PKT_SUBTYPE;
    // only the one pairing is served here, so one counter suffices
    seqOk = seqCountField == expectedSeq;
  end

  // ----------------------------------------------------------------------
  // verdict once the check word is in
  // ----------------------------------------------------------------------
  always_comb begin
    verdict = amp_cmd_pkg::VERDICT_NONE;
    if (state == amp_cmd_pkg::PK_CHECK) begin
      if (checkField != crcFirst) begin
        verdict = amp_cmd_pkg::VERDICT_CKSUM;
      end else if (!headerOk) begin
        verdict = amp_cmd_pkg::VERDICT_HEADER;
      end else if (!classOk) begin
        verdict = amp_cmd_pkg::VERDICT_OTHER;
      end else if (!seqOk) begin
        verdict = amp_cmd_pkg::VERDICT_SEQ;
      end else if (dataField != `CMD_POWER_ON
                   && dataField != `CMD_POWER_OFF) begin
        verdict = amp_cmd_pkg::VERDICT_OTHER;
      end else begin
        verdict = amp_cmd_pkg::VERDICT_OK;
      end
    end
  end

  assign crcFirst = crc;

  // ----------------------------------------------------------------------
  // packet receiver and command execution
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_wordIdx = wordIdx;
    next_hdr = hdr;
    next_expectedSeq = expectedSeq;
    next_ampCtrl = ampCtrl;
    next_cmdAccept = 1'b0;
    next_cmdReject = 1'b0;
    next_acceptCount = acceptCount;
    next_rejectCount = rejectCount;
    next_lastVerdict = lastVerdict;
    case (state)
      amp_cmd_pkg::PK_IDLE: begin
        if (tcValid && tcFirst) begin
          next_hdr[0] = tcWord;
          next_wordIdx = 4'h1;
          next_state = amp_cmd_pkg::PK_BODY;
        end
      end
      amp_cmd_pkg::PK_BODY: begin
        if (tcValid && tcFirst) begin
          // a new start drops a truncated packet without executing it
          next_hdr[0] = tcWord;
          next_wordIdx = 4'h1;
          next_rejectCount = rejectCount + 8'h01;
          next_lastVerdict = amp_cmd_pkg::VERDICT_HEADER;
          next_cmdReject = 1'b1;
        end else if (tcValid) begin
          next_hdr[wordIdx[2:0]] = tcWord;
          next_wordIdx = wordIdx + 4'h1;
          if (wordIdx == `PKT_WORDS - 4'h1) begin
            next_state = amp_cmd_pkg::PK_CHECK;
          end
        end
      end
      amp_cmd_pkg::PK_CHECK: begin
        next_state = amp_cmd_pkg::PK_IDLE;
        next_lastVerdict = verdict;
        if (verdict == amp_cmd_pkg::VERDICT_OK) begin
          next_ampCtrl = ~hdr[6][0];
          next_expectedSeq = expectedSeq + 1'b1;
          next_acceptCount = acceptCount + 8'h01;
          next_cmdAccept = 1'b1;
        end else begin
          // every refused packet is counted and pulsed, bad data too
          next_rejectCount = rejectCount + 8'h01;
          next_cmdReject = 1'b1;
        end
      end
      default: next_state = amp_cmd_pkg::PK_IDLE;
    endcase
    if (swRestart) begin
      next_ampCtrl = `AMP_CTRL_RESET;
    end
  end

  // registers only; reset leaves the amplifier on and the bus idle
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= amp_cmd_pkg::PK_IDLE;
      wordIdx <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        hdr[i] <= 16'h0000;
      end
      expectedSeq <= '0;
      ampCtrl <= `AMP_CTRL_RESET;
      cmdAccept <= 1'b0;
      cmdReject <= 1'b0;
      acceptCount <= 8'h00;
      rejectCount <= 8'h00;
      lastVerdict <= amp_cmd_pkg::VERDICT_NONE;
    end else begin
      state <= next_state;
      wordIdx <= next_wordIdx;
      hdr <= next_hdr;
      expectedSeq <= next_expectedSeq;
      ampCtrl <= next_ampCtrl;
      cmdAccept <= next_cmdAccept;
      cmdReject <= next_cmdReject;
      acceptCount <= next_acceptCount;
      rejectCount <= next_rejectCount;
      lastVerdict <= next_lastVerdict;
    end
  end
endmodule : mm_amp_power_command_decoder

// ---- mm_amp_power_command_decoder_properties.sv ----
// port checker for the amplifier power command decoder
// assumes: bound to the decoder top; one clock mclk, sync reset rst
`timescale 1ns/100ps
module mm_amp_power_command_decoder_properties #(
  parameter int SEQ_WIDTH = 11
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tcValid,
  input wire logic tcFirst,
  input wire logic [15:0] tcWord,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic ampCtrl,
  input wire logic cmdAccept,
  input wire logic cmdReject
);
  // ----------------------------------------------------------------
  // packet position tracking
  // ----------------------------------------------------------------
  logic [3:0] wordCnt;
  logic dataBit;
  logic lastWord;
  assign lastWord = tcValid && wordCnt == 4'h7;
  // counts words taken so verdicts can be tied to the closing word
  always_ff @(posedge mclk) begin
    if (rst) begin
      wordCnt <= 4'h0;
    end else if (tcValid) begin
      wordCnt <= tcFirst ? 4'h1 : wordCnt + 4'h1;
    end
    if (tcValid && wordCnt == 4'h6) begin
      dataBit <= tcWord[0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  amp_on_reset_a: assert property (
    disable iff (1'b0) rst |=> !ampCtrl && waitrequest)
    else $error("amp not on after reset");
  verdict_time_a: assert property (
    lastWord |-> ##2 (cmdAccept ^ cmdReject))
    else $error("no single verdict two cycles after last word");
  verdict_cause_a: assert property (
    (cmdAccept || cmdReject) |-> $past(lastWord, 2))
    else $error("verdict without a finished packet");
  verdict_pulse_a: assert property (
    (cmdAccept || cmdReject) |=> !(cmdAccept || cmdReject) [*8])
    else $error("verdict pulse too long");
  amp_rise_a: assert property (
    $rose(ampCtrl) |-> cmdAccept)
    else $error("amp switched off without a command");
  accept_value_a: assert property (
    cmdAccept |-> ampCtrl == !dataBit)
    else $error("control bit not inverse of command");
  ctrl_image_a: assert property (
    !waitrequest && $past(read) && $past(address) == 4'h0
      |-> readdata[8] == ampCtrl)
    else $error("control word bit 8 wrong");
  readback_bit_a: assert property (
    !waitrequest && $past(read) && $past(address) == 4'h8
      |-> readdata[7] == ampCtrl)
    else $error("readback bit 7 wrong");
  unmapped_zero_a: assert property (
    !waitrequest && $past(read) && $past(address) == 4'h2
      |-> readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : mm_amp_power_command_decoder_properties

// ---- tc_source.sv ----
// ground telecommand source model for the decoder packet port
// assumes: send is called from the bench top by hierarchical name
`timescale 1ns/100ps
module tc_source (
  input wire logic mclk,
  output logic tcValid,
  output logic tcFirst,
  output logic [15:0] tcWord
);
  initial begin
    tcValid = 1'b0;
    tcFirst = 1'b0;
    tcWord = 16'h0000;
  end
  // crc-16 msb first, polynomial 1021
  function automatic logic [15:0] crcStep(logic [15:0] c, logic [15:0] w);
    for (int b = 15; b >= 0; b--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[b]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crcStep
  // kind: 0 clean, 1 crc, 2 id, 3 length, 4 ack, 5 subtype, 6 type
  task automatic send(input logic [15:0] d, input logic [10:0] seq,
                      input int kind);
    logic [15:0] w [8];
    logic [15:0] c;
    w[0] = {3'h0, 1'h1, 1'h1, (kind == 2) ? 7'h46 : 7'h47, 4'hc};
    w[1] = {2'h3, 3'h0, seq};
    w[2] = (kind == 3) ? 16'h0009 : 16'h0007;
    w[3] = {4'h0, 1'h1, 7'h00, (kind == 4) ? 4'h0 : 4'h1};
    w[4] = {(kind == 6) ? 8'hc1 : 8'hc0,
            (kind == 5) ? 8'h08 : 8'h07};
    w[5] = 16'h0000;
    w[6] = d;
    c = 16'hffff;
    for (int i = 1; i < 7; i++) begin
      c = crcStep(c, w[i]);
    end
    w[7] = (kind == 1) ? ~c : c;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      tcValid <= 1'b1;
      tcFirst <= (i == 0);
      tcWord <= w[i];
    end
    // released word line shows no stale value
    @(posedge mclk);
    tcValid <= 1'b0;
    tcFirst <= 1'b0;
    tcWord <= ~w[7];
  endtask : send
endmodule : tc_source

// ---- mm_amp_power_command_decoder_tb_top.sv ----
// self-checking bench for the amplifier power command decoder
// assumes: tc_source model on the packet port, checker bound below
`timescale 1ns/100ps
module mm_amp_power_command_decoder_tb_top;
  logic mclk, rst, read, write, waitrequest, ampCtrl, cmdAccept;
  logic cmdReject, tcValid, tcFirst, expAmp;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] tcWord;
  logic [10:0] seq;
  int mismatches = 0;
  int checksDone = 0;
  typedef struct {logic [15:0] data; int kind; logic acc;} row_s;
  // kind 7 sends a sequence count one ahead
  row_s rows [11] = '{'{16'h0, 0, 1'b1}, '{16'h1, 0, 1'b1},
    '{16'h0, 1, 1'b0}, '{16'h0, 2, 1'b0}, '{16'h0, 3, 1'b0},
    '{16'h0, 4, 1'b0}, '{16'h0, 5, 1'b0}, '{16'h0, 6, 1'b0},
    '{16'h2, 0, 1'b0}, '{16'h0, 7, 1'b0}, '{16'h0, 0, 1'b1}};
  mm_amp_power_command_decoder #(.SEQ_WIDTH(11)) dut (.mclk, .rst,
    .tcValid, .tcFirst, .tcWord, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .ampCtrl, .cmdAccept,
    .cmdReject);
  tc_source src (.mclk, .tcValid, .tcFirst, .tcWord);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checksDone++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic ranOut;
    mismatches++;
    $display("MISMATCH t=%0t wait ran out", $time);
    close_out();
  endtask : ranOut
  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // waitrequest and read data are taken as they stand at the edge
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) break;
    end
    if (n == 20) ranOut();
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic cmd(input logic [15:0] d, input int k, input logic acc);
    int n;
    src.send(d, (k == 7) ? seq + 11'h1 : seq, k);
    for (n = 0; n < 12; n++) begin
      @(posedge mclk);
      #1;
      if ((cmdAccept | cmdReject) === 1'b1) break;
    end
    if (n == 12) ranOut();
    check(cmdAccept, acc);
    check(cmdReject, !acc);
    if (acc) begin
      expAmp = !d[0];
      seq = seq + 11'h1;
    end
    check(ampCtrl, expAmp);
  endtask : cmd
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    expAmp = 1'b0;
    seq = 11'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    check(ampCtrl, 1'b0);
    $display("test reset done");
    foreach (rows[i]) cmd(rows[i].data, rows[i].kind, rows[i].acc);
    $display("test packet table done");
    bus(1'b0, 4'h0, 32'h0);
    check(rd[8], expAmp);
    bus(1'b0, 4'h8, 32'h0);
    check(rd[7], expAmp);
    bus(1'b0, 4'hc, 32'h0);
    check(rd[10:0], seq);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    // status: last verdict ok, 8 refused, 3 taken
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'h00010803);
    // software restart puts the amplifier back on
    bus(1'b1, 4'h0, 32'h1);
    repeat (4) @(posedge mclk);
    check(ampCtrl, 1'b0);
    expAmp = 1'b0;
    $display("test registers done");
    // reset mid-run clears the bit and the sequence count
    cmd(16'h0, 0, 1'b1);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check(ampCtrl, 1'b0);
    expAmp = 1'b0;
    seq = 11'h0;
    cmd(16'h0, 0, 1'b1);
    $display("test second reset done");
    close_out();
  end
endmodule : mm_amp_power_command_decoder_tb_top
bind mm_amp_power_command_decoder mm_amp_power_command_decoder_properties
  #(.SEQ_WIDTH(SEQ_WIDTH)) chk (.mclk, .rst, .tcValid, .tcFirst, .tcWord,
  .address, .read, .readdata, .waitrequest, .ampCtrl, .cmdAccept,
  .cmdReject);
